// ---- sdb_device.sv ----
// device end: stacked flash, sram and psram dies on one shared bus
// Function
// - top used address bit follows die density
// - each address step is one 16-bit word
// - host leaves the two top address bits unused
// - data bus carries writes in, reads out
// - device floats data when deselected or disabled
// - flash write data captured into a latch
// - flash enable low activates, high floats outputs
// - three flash enables, extra ones reserved
// - sram active only with both selects asserted
// - host keeps sram selects idle without sram
// - psram active while its select is low
// - psram selects reserved when die absent
// - flash output enable low turns drivers on
// - second flash output enable serves dies two, three
// - ram output enable, reserved on flash-only stacks
// - flash write taken on strobe rising edge
// - ram write strobe, reserved on flash-only stacks
// - wait asserted level set by config bit ten
`timescale 1ns/1ps
module sdb_device #(
  parameter sdb_pkg::sdb_density_e DENSITY = sdb_pkg::DENS_128M,
  parameter int FLASH_COUNT = 3,
  parameter bit SRAM_FITTED = 1'b1,
  parameter int PSRAM_COUNT = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // shared bus
  sdb_bus_if.device bus,
  // configuration
  input wire logic [sdb_pkg::DATA_W-1:0] read_config_i,
  // status
  output logic [sdb_pkg::DATA_W-1:0] flash_latch_o,
  output logic [sdb_pkg::ADDR_W-1:0] latch_addr_o,
  output logic [sdb_pkg::FLASH_DIES-1:0] flash_active_o,
  output logic [sdb_pkg::RAM_DIES-1:0] ram_active_o
);
  localparam int DW = sdb_pkg::DATA_W;
  localparam int AW = sdb_pkg::ADDR_W;
  localparam int NW = sdb_pkg::MEM_WORDS;

  // ==========================================================
  // die decode helpers
  // die 0 has its own output enable
  // dies 1 and 2 share the second one
  function automatic int flash_oe_bit(input int die);
    return (die == 0) ? 0 : 1;
  endfunction : flash_oe_bit

  // reserved enables select nothing
  function automatic logic flash_fitted(input int die);
    return die < FLASH_COUNT;
  endfunction : flash_fitted

  // ram die index: 0 sram, 1 psram one, 2 psram two
  function automatic logic ram_die_fitted(input int die);
    unique case (die)
      0: return SRAM_FITTED;
      1: return PSRAM_COUNT > 0;
      default: return PSRAM_COUNT > 1;
    endcase
  endfunction : ram_die_fitted

  typedef struct packed {
    logic [sdb_pkg::FLASH_DIES-1:0][NW-1:0][DW-1:0] flash_mem;
    logic [sdb_pkg::RAM_DIES-1:0][NW-1:0][DW-1:0] ram_mem;
    logic [DW-1:0] flash_latch;
    logic [AW-1:0] latch_addr;
    logic flash_we_n_d;
    logic [DW-1:0] dout;
    logic dout_oe;
    logic wait_level;
    logic wait_oe;
    logic [sdb_pkg::FLASH_DIES-1:0] flash_active;
    logic [sdb_pkg::RAM_DIES-1:0] ram_active;
  } sdb_dev_state_s;

  sdb_dev_state_s s;
  sdb_dev_state_s next_s;

  // ==========================================================
  // pin synchronisers
  // two flops per pin, so answers lag the pins by three edges
  sdb_pkg::sdb_pins_s pins;
  logic [DW-1:0] bus_data;
  logic [sdb_pkg::PINS_W-1:0] pins_raw;

  sdb_sync #(
    .W(sdb_pkg::PINS_W),
    .RST_VAL(sdb_pkg::PINS_IDLE)
  ) u_pin_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .d_i(bus.host_pins),
    .q_o(pins_raw)
  );

  assign pins = sdb_pkg::sdb_pins_s'(pins_raw);

  sdb_sync #(
    .W(DW),
    .RST_VAL(16'h0000)
  ) u_data_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .d_i(bus.data_bus),
    .q_o(bus_data)
  );

  // ==========================================================
  // select decode
  logic [AW-1:0] addr_used;
  logic [sdb_pkg::MEM_AW-1:0] idx;
  logic [sdb_pkg::FLASH_DIES-1:0] flash_sel;
  logic [sdb_pkg::FLASH_DIES-1:0] flash_out_on;
  logic [sdb_pkg::RAM_DIES-1:0] ram_sel;
  logic ram_fitted;
  logic ram_out_on;
  logic ram_write;
  logic flash_we_rise;

  always_comb begin
    // density mask, then the low bits index the model's 16 words
    addr_used = pins.addr & sdb_pkg::addr_mask(DENSITY);
    idx = addr_used[sdb_pkg::MEM_AW-1:0];
    ram_fitted = ram_die_fitted(0) || ram_die_fitted(1);
    for (int i = 0; i < sdb_pkg::FLASH_DIES; i++) begin
      flash_sel[i] = !pins.flash_ce_n[i] && flash_fitted(i);
      flash_out_on[i] = flash_sel[i] && !pins.flash_oe_n[flash_oe_bit(i)];
    end
    ram_sel[0] = ram_die_fitted(0) && !pins.sram_select_low_true_n
      && pins.sram_select_high_true;
    ram_sel[1] = ram_die_fitted(1) && !pins.psram_cs_n[0];
    ram_sel[2] = ram_die_fitted(2) && !pins.psram_cs_n[1];
    ram_out_on = ram_fitted && !pins.ram_oe_n && (|ram_sel);
    ram_write = ram_fitted && !pins.ram_we_n;
    // synced data lags by the same two flops as the strobe
    flash_we_rise = !s.flash_we_n_d && pins.flash_we_n;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.flash_we_n_d = pins.flash_we_n;
    next_s.flash_active = flash_sel;
    next_s.ram_active = ram_sel;
    // bus released unless a die is both selected and enabled
    next_s.dout_oe = 1'b0;
    for (int i = 0; i < sdb_pkg::FLASH_DIES; i++) begin
      if (flash_out_on[i] && !next_s.dout_oe) begin
        next_s.dout_oe = 1'b1;
        next_s.dout = s.flash_mem[i][idx];
      end
      if (flash_sel[i] && flash_we_rise) begin
        next_s.flash_mem[i][idx] = bus_data;
        next_s.flash_latch = bus_data;
        next_s.latch_addr = addr_used;
      end
    end
    for (int k = 0; k < sdb_pkg::RAM_DIES; k++) begin
      // first enabled die wins if the host breaks single-driver use
      if (ram_out_on && ram_sel[k] && !next_s.dout_oe) begin
        next_s.dout_oe = 1'b1;
        next_s.dout = s.ram_mem[k][idx];
      end
      if (ram_write && ram_sel[k]) begin
        next_s.ram_mem[k][idx] = bus_data;
      end
    end
    // asynchronous reads and writes only: wait sits at its asserted level
    next_s.wait_oe = |flash_sel;
    next_s.wait_level = read_config_i[sdb_pkg::WAIT_POL_BIT];
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      // strobe history starts high so reset gives no false rise
      s.flash_we_n_d <= 1'b1;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign bus.dev_data = s.dout;
  assign bus.dev_data_oe = s.dout_oe;
  assign bus.wait_level = s.wait_level;
  // wait enable follows flash select, not output enable
  assign bus.wait_oe = s.wait_oe;

  // ==========================================================
  // die status
  assign flash_latch_o = s.flash_latch;
  assign latch_addr_o = s.latch_addr;
  assign flash_active_o = s.flash_active;
  assign ram_active_o = s.ram_active;
endmodule : sdb_device

// ---- sdb_pkg.sv ----
// shared constants, types and helpers for the stacked-die bus select ends
package sdb_pkg;

  // ==========================================================
  // widths and die counts
  localparam int DATA_W = 16;
  localparam int ADDR_W = 26;
  localparam int RESV_LO = 24;
  localparam int FLASH_DIES = 3;
  localparam int RAM_DIES = 3;
  localparam int MEM_AW = 4;
  localparam int MEM_WORDS = 16;
  localparam int WAIT_POL_BIT = 10;

  // ==========================================================
  // top used address bit per die density
  localparam int TOP_BIT_256M = 23;
  localparam int TOP_BIT_128M = 22;
  localparam int TOP_BIT_64M = 21;
  localparam int TOP_BIT_32M = 20;
  localparam int TOP_BIT_8M = 18;

  // ==========================================================
  // host strobe timing in clock cycles
  localparam int SETUP_CYCLES = 3;
  localparam int STROBE_CYCLES = 8;
  localparam int RELEASE_CYCLES = 3;
  localparam int CNT_W = 4;

  typedef enum logic [2:0] {
    DENS_8M,
    DENS_32M,
    DENS_64M,
    DENS_128M,
    DENS_256M
  } sdb_density_e;

  typedef enum logic [2:0] {
    TGT_FLASH1,
    TGT_FLASH2,
    TGT_FLASH3,
    TGT_SRAM,
    TGT_PSRAM1,
    TGT_PSRAM2
  } sdb_target_e;

  // host-driven pins, flash die n on index n-1, psram die n on index n-1
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wdata_oe;
    logic [2:0] flash_ce_n;
    logic sram_select_low_true_n;
    logic sram_select_high_true;
    logic [1:0] psram_cs_n;
    logic [1:0] flash_oe_n;
    logic ram_oe_n;
    logic flash_we_n;
    logic ram_we_n;
  } sdb_pins_s;

  localparam sdb_pins_s PINS_IDLE = '{
    addr: 26'h0000000,
    wdata: 16'h0000,
    wdata_oe: 1'h0,
    flash_ce_n: 3'h7,
    sram_select_low_true_n: 1'h1,
    sram_select_high_true: 1'h0,
    psram_cs_n: 2'h3,
    flash_oe_n: 2'h3,
    ram_oe_n: 1'h1,
    flash_we_n: 1'h1,
    ram_we_n: 1'h1
  };

  localparam int PINS_W = $bits(sdb_pins_s);

  function automatic int top_address_bit(input sdb_density_e d);
    unique case (d)
      DENS_8M: return TOP_BIT_8M;
      DENS_32M: return TOP_BIT_32M;
      DENS_64M: return TOP_BIT_64M;
      DENS_128M: return TOP_BIT_128M;
      DENS_256M: return TOP_BIT_256M;
      default: return TOP_BIT_8M;
    endcase
  endfunction : top_address_bit

  function automatic logic [ADDR_W-1:0] addr_mask(input sdb_density_e d);
    logic [ADDR_W-1:0] m;
    m = '0;
    for (int i = 0; i < ADDR_W; i++) begin
      m[i] = (i <= top_address_bit(d));
    end
    return m;
  endfunction : addr_mask

  function automatic logic target_is_ram(input sdb_target_e t);
    return (t == TGT_SRAM) || (t == TGT_PSRAM1) || (t == TGT_PSRAM2);
  endfunction : target_is_ram

endpackage : sdb_pkg

// ---- sdb_bus_if.sv ----
// shared memory bus between host controller and stacked-die device
`timescale 1ns/1ps
interface sdb_bus_if;
  sdb_pkg::sdb_pins_s host_pins;
  logic [sdb_pkg::DATA_W-1:0] dev_data;
  logic dev_data_oe;
  logic wait_level;
  logic wait_oe;
  logic [sdb_pkg::DATA_W-1:0] data_bus;

  // ==========================================================
  // resolved data wire: device wins only while it drives
  assign data_bus = dev_data_oe ? dev_data : host_pins.wdata;

  modport device (
    input host_pins,
    input data_bus,
    output dev_data,
    output dev_data_oe,
    output wait_level,
    output wait_oe
  );

  modport host (
    output host_pins,
    input data_bus,
    input wait_level,
    input wait_oe
  );
endinterface : sdb_bus_if

// ---- sdb_sync.sv ----
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sdb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sdb_sync_s;

  sdb_sync_s s;
  sdb_sync_s next_s;

  always_comb begin
    next_s.meta = d_i;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '{meta: RST_VAL, stable: RST_VAL};
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign q_o = s.stable;
endmodule : sdb_sync

// ---- sdb_host.sv ----
// host end: memory controller driving selects and strobes on the shared bus
`timescale 1ns/1ps
module sdb_host #(
  parameter int FLASH_COUNT = 3,
  parameter bit SRAM_FITTED = 1'b1,
  parameter int PSRAM_COUNT = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // shared bus
  sdb_bus_if.host bus,
  // request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire sdb_pkg::sdb_target_e req_target_i,
  input wire logic [sdb_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [sdb_pkg::DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  // answer
  output logic rsp_valid_o,
  output logic [sdb_pkg::DATA_W-1:0] rsp_rdata_o,
  output logic wait_o
);
  localparam int DW = sdb_pkg::DATA_W;

  typedef enum logic [1:0] {
    H_IDLE,
    H_SETUP,
    H_STROBE,
    H_RELEASE
  } sdb_host_state_e;

  typedef struct packed {
    sdb_host_state_e state;
    sdb_pkg::sdb_pins_s pins;
    logic [sdb_pkg::CNT_W-1:0] cnt;
    logic write;
    logic ram;
    logic rsp_valid;
    logic [DW-1:0] rdata;
  } sdb_host_s;

  sdb_host_s s;
  sdb_host_s next_s;
  logic [DW+1:0] in_sync;
  logic fitted;

  // ==========================================================
  // device pins synchronised before use
  sdb_sync #(
    .W(DW + 2),
    .RST_VAL(18'h00000)
  ) u_in_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .d_i({bus.wait_oe, bus.wait_level, bus.data_bus}),
    .q_o(in_sync)
  );

  always_comb begin
    unique case (req_target_i)
      sdb_pkg::TGT_FLASH1: fitted = (FLASH_COUNT > 0);
      sdb_pkg::TGT_FLASH2: fitted = (FLASH_COUNT > 1);
      sdb_pkg::TGT_FLASH3: fitted = (FLASH_COUNT > 2);
      sdb_pkg::TGT_SRAM: fitted = SRAM_FITTED;
      sdb_pkg::TGT_PSRAM1: fitted = (PSRAM_COUNT > 0);
      sdb_pkg::TGT_PSRAM2: fitted = (PSRAM_COUNT > 1);
      default: fitted = 1'b0;
    endcase
  end

  // ==========================================================
  // strobe sequencer
  always_comb begin
    next_s = s;
    next_s.rsp_valid = 1'b0;
    unique case (s.state)
      H_IDLE: begin
        if (req_valid_i && !fitted && !req_write_i) begin
          next_s.rsp_valid = 1'b1;
          next_s.rdata = '0;
        end else if (req_valid_i && fitted) begin
          next_s.state = H_SETUP;
          next_s.cnt = sdb_pkg::CNT_W'(sdb_pkg::SETUP_CYCLES - 1);
          next_s.write = req_write_i;
          next_s.ram = sdb_pkg::target_is_ram(req_target_i);
          next_s.pins = sdb_pkg::PINS_IDLE;
          next_s.pins.addr = req_addr_i;
          next_s.pins.addr[sdb_pkg::ADDR_W-1:sdb_pkg::RESV_LO] = 2'h0;
          next_s.pins.wdata = req_wdata_i;
          next_s.pins.wdata_oe = req_write_i;
          // exactly one die selected per access
          unique case (req_target_i)
            sdb_pkg::TGT_FLASH1: next_s.pins.flash_ce_n = 3'h6;
            sdb_pkg::TGT_FLASH2: next_s.pins.flash_ce_n = 3'h5;
            sdb_pkg::TGT_FLASH3: next_s.pins.flash_ce_n = 3'h3;
            sdb_pkg::TGT_SRAM: begin
              next_s.pins.sram_select_low_true_n = 1'b0;
              next_s.pins.sram_select_high_true = 1'b1;
            end
            sdb_pkg::TGT_PSRAM1: next_s.pins.psram_cs_n = 2'h2;
            sdb_pkg::TGT_PSRAM2: next_s.pins.psram_cs_n = 2'h1;
            default: next_s.pins = sdb_pkg::PINS_IDLE;
          endcase
        end
      end
      H_SETUP: begin
        next_s.cnt = s.cnt - 1'b1;
        if (s.cnt == '0) begin
          next_s.state = H_STROBE;
          next_s.cnt = sdb_pkg::CNT_W'(sdb_pkg::STROBE_CYCLES - 1);
          if (s.write && s.ram) next_s.pins.ram_we_n = 1'b0;
          if (s.write && !s.ram) next_s.pins.flash_we_n = 1'b0;
          if (!s.write && s.ram) next_s.pins.ram_oe_n = 1'b0;
          if (!s.write && !s.ram) begin
            next_s.pins.flash_oe_n = (s.pins.flash_ce_n[0]) ? 2'h1 : 2'h2;
          end
        end
      end
      H_STROBE: begin
        next_s.cnt = s.cnt - 1'b1;
        if (s.cnt == '0) begin
          next_s.state = H_RELEASE;
          next_s.cnt = sdb_pkg::CNT_W'(sdb_pkg::RELEASE_CYCLES - 1);
          next_s.pins.ram_we_n = 1'b1;
          next_s.pins.flash_we_n = 1'b1;
          next_s.pins.ram_oe_n = 1'b1;
          next_s.pins.flash_oe_n = 2'h3;
          if (!s.write) begin
            next_s.rsp_valid = 1'b1;
            next_s.rdata = in_sync[DW-1:0];
          end
        end
      end
      H_RELEASE: begin
        next_s.cnt = s.cnt - 1'b1;
        if (s.cnt == '0) begin
          next_s.state = H_IDLE;
          next_s.pins = sdb_pkg::PINS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '{state: H_IDLE, pins: sdb_pkg::PINS_IDLE, default: '0};
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign bus.host_pins = s.pins;
  assign req_ready_o = (s.state == H_IDLE) && ce_i;
  assign rsp_valid_o = s.rsp_valid;
  assign rsp_rdata_o = s.rdata;
  assign wait_o = in_sync[DW+1] && in_sync[DW];
endmodule : sdb_host

// ---- sdb_bus_sva.sv ----
// concurrent checks on the shared bus between host and device ends
`timescale 1ns/1ps
module sdb_bus_sva (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // bus signals
  input wire sdb_pkg::sdb_pins_s host_pins,
  input wire logic [sdb_pkg::DATA_W-1:0] dev_data,
  input wire logic dev_data_oe,
  input wire logic wait_level,
  input wire logic wait_oe,
  input wire logic [sdb_pkg::DATA_W-1:0] data_bus
);
  // ==========================================================
  // select decode: [5:3] flash 3..1, [2:1] psram 2..1, [0] sram
  logic [5:0] sel_on;
  logic no_sel;
  logic no_oe;

  assign sel_on = {~host_pins.flash_ce_n, ~host_pins.psram_cs_n,
                   ~host_pins.sram_select_low_true_n & host_pins.sram_select_high_true};
  assign no_sel = (sel_on == 6'h00);
  assign no_oe = (host_pins.flash_oe_n == 2'h3) && host_pins.ram_oe_n;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  // ==========================================================
  // assertions
  a_float_unselected: assert property (
    no_sel [*4] |-> !dev_data_oe) else $error("data driven while no die selected");
  a_float_oe_high: assert property (
    no_oe [*4] |-> !dev_data_oe) else $error("data driven with outputs disabled");
  a_wait_float: assert property (
    (sel_on[5:3] == 3'h0) [*4] |-> !wait_oe) else $error("wait driven while flash idle");
  a_wait_driven: assert property (
    (sel_on[5:3] != 3'h0) [*4] |-> wait_oe) else $error("wait not driven while flash on");
  a_flash1_read: assert property (
    (sel_on[3] && !host_pins.flash_oe_n[0]) [*4] |-> dev_data_oe && data_bus == dev_data)
    else $error("flash die one read not driven");
  a_flash23_read: assert property (
    (sel_on[5:4] != 2'h0 && !host_pins.flash_oe_n[1]) [*4] |-> dev_data_oe)
    else $error("flash die two or three read not driven");
  a_ram_read: assert property (
    (sel_on[2:0] != 3'h0 && !host_pins.ram_oe_n) [*4] |-> dev_data_oe)
    else $error("ram read not driven");
  a_one_select: assert property (
    $onehot0(sel_on)) else $error("several dies selected");
  a_no_contention: assert property (
    !(host_pins.wdata_oe && dev_data_oe)) else $error("host and device both drive data");
  a_strobe_width: assert property (
    $fell(host_pins.flash_we_n) |-> (!host_pins.flash_we_n) [*8] ##1 host_pins.flash_we_n)
    else $error("flash write strobe width wrong");
  a_write_data: assert property (
    (!host_pins.flash_we_n || !host_pins.ram_we_n) |-> host_pins.wdata_oe)
    else $error("write strobe without host data");
  a_top_addr_zero: assert property (
    host_pins.addr[25:24] == 2'h0) else $error("reserved address bits used");
  a_wait_steady: assert property (
    wait_oe && $past(wait_oe) |-> $stable(wait_level)) else $error("wait level moved");
endmodule : sdb_bus_sva

// ---- stacked_die_bus_select_tb.sv ----
// testbench joining host and device ends over the shared bus
`timescale 1ns/1ps
module stacked_die_bus_select_tb;
  logic clock_i;
  logic reset_n_i;
  logic ce_i;
  logic [15:0] read_config_i;
  logic req_valid_i;
  logic req_write_i;
  sdb_pkg::sdb_target_e req_target_i;
  logic [25:0] req_addr_i;
  logic [15:0] req_wdata_i;
  logic req_ready_o;
  logic rsp_valid_o;
  logic [15:0] rsp_rdata_o;
  logic wait_o;
  logic [15:0] flash_latch_o;
  logic [25:0] latch_addr_o;
  logic [2:0] flash_active_o;
  logic [2:0] ram_active_o;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  // ==========================================================
  // instances
  sdb_bus_if bus ();
  sdb_host i_sdb_host (.clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .bus(bus.host), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_target_i(req_target_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .wait_o(wait_o));
  sdb_device #(.DENSITY(sdb_pkg::DENS_128M)) i_sdb_device (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .ce_i(ce_i), .bus(bus.device), .read_config_i(read_config_i),
    .flash_latch_o(flash_latch_o), .latch_addr_o(latch_addr_o),
    .flash_active_o(flash_active_o), .ram_active_o(ram_active_o));
  sdb_bus_sva i_sdb_bus_sva (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .host_pins(bus.host_pins), .dev_data(bus.dev_data), .dev_data_oe(bus.dev_data_oe),
    .wait_level(bus.wait_level), .wait_oe(bus.wait_oe), .data_bus(bus.data_bus));

  always #12.5 clock_i = ~clock_i;

  // ==========================================================
  // shared tasks
  task automatic check(input logic [25:0] got, input logic [25:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clock_i);
    while (req_ready_o !== 1'b1 && n < 40) begin
      @(negedge clock_i);
      n++;
    end
    check(req_ready_o, 1'b1);
  endtask : wait_ready

  task automatic xfer(input sdb_pkg::sdb_target_e t, input logic w, input logic [25:0] a,
                      input logic [15:0] d);
    wait_ready();
    req_valid_i = 1'b1;
    req_write_i = w;
    req_target_i = t;
    req_addr_i = a;
    req_wdata_i = d;
    @(negedge clock_i);
    req_valid_i = 1'b0;
  endtask : xfer

  task automatic rd(input sdb_pkg::sdb_target_e t, input logic [25:0] a, input logic [15:0] d);
    int n;
    logic [5:0] act;
    n = 0;
    act = (t < 3) ? (6'h08 << t) : (6'h01 << (t - 3));
    xfer(t, 1'b0, a, 16'h0000);
    while (rsp_valid_o !== 1'b1 && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    check(rsp_valid_o, 1'b1);
    check(rsp_rdata_o, d);
    check({flash_active_o, ram_active_o}, act);
    check(wait_o, (t < 3) ? read_config_i[10] : 1'b0);
  endtask : rd

  // ==========================================================
  // scenarios
  task automatic t_targets();
    for (int i = 0; i < 6; i++) begin
      xfer(sdb_pkg::sdb_target_e'(i), 1'b1, 26'h0000003, 16'hA5C0 + 16'(i));
    end
    for (int i = 0; i < 6; i++) begin
      rd(sdb_pkg::sdb_target_e'(i), 26'h0000003, 16'hA5C0 + 16'(i));
    end
    $display("t_targets finished");
  endtask : t_targets

  task automatic t_words();
    xfer(sdb_pkg::TGT_FLASH1, 1'b1, 26'h0000001, 16'h1111);
    xfer(sdb_pkg::TGT_FLASH1, 1'b1, 26'h0000002, 16'h2222);
    rd(sdb_pkg::TGT_FLASH1, 26'h0000001, 16'h1111);
    rd(sdb_pkg::TGT_FLASH1, 26'h0000002, 16'h2222);
    $display("t_words finished");
  endtask : t_words

  task automatic t_latch();
    xfer(sdb_pkg::TGT_FLASH2, 1'b1, 26'h3C00007, 16'hBEEF);
    wait_ready();
    repeat (4) @(negedge clock_i);
    check(flash_latch_o, 16'hBEEF);
    check(latch_addr_o, 26'h0400007);
    xfer(sdb_pkg::TGT_PSRAM1, 1'b1, 26'h0000008, 16'h0F0F);
    wait_ready();
    repeat (4) @(negedge clock_i);
    check(flash_latch_o, 16'hBEEF);
    $display("t_latch finished");
  endtask : t_latch

  task automatic t_polarity();
    wait_ready();
    // let the wait enable drop before the polarity moves
    repeat (4) @(negedge clock_i);
    read_config_i = 16'h0000;
    rd(sdb_pkg::TGT_FLASH3, 26'h0000003, 16'hA5C2);
    wait_ready();
    repeat (4) @(negedge clock_i);
    read_config_i = 16'h0400;
    rd(sdb_pkg::TGT_FLASH1, 26'h0000003, 16'hA5C0);
    $display("t_polarity finished");
  endtask : t_polarity

  task automatic t_standby();
    wait_ready();
    repeat (6) @(negedge clock_i);
    check({flash_active_o, ram_active_o}, 6'h00);
    check(bus.dev_data_oe, 1'b0);
    check(bus.wait_oe, 1'b0);
    $display("t_standby finished");
  endtask : t_standby

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // timeout and main sequence
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    clock_i = 1'b0;
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    read_config_i = 16'h0400;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_target_i = sdb_pkg::TGT_FLASH1;
    req_addr_i = 26'h0000000;
    req_wdata_i = 16'h0000;
    repeat (20) @(negedge clock_i);
    reset_n_i = 1'b1;
    t_targets();
    t_words();
    t_latch();
    t_polarity();
    t_standby();
    tally_and_finish();
  end
endmodule : stacked_die_bus_select_tb
